// ===== core_interrupt_control_register.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_register
    import irq_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [10:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    input  wire logic        timer0_overflow,
    input  wire logic        periph_request,
    input  wire logic        external_edge_select,
    input  wire logic        external_irq_pin,
    input  wire logic [3:0]  upper_port_pins,
    input  wire logic        port_read,
    output var  logic        core_irq_r
);
    logic [7:0] ctl_r;
    logic       pc_flag_r;
    logic       pin_s1_r, pin_s2_r, pin_d_r;
    logic [3:0] up_s1_r, up_s2_r, up_latch_r;
    logic       ack_r;
    logic [8:0] idx;
    logic       hit, acc, wr_go, ext_edge, mismatch;
    logic [1:0] sync_fill_r;
    logic       edge_armed;

    function automatic logic is_ctl(input logic [8:0] i);
        return (i == INTCS_IDX0_FULL) || (i == INTCS_IDX1_FULL) ||
               (i == INTCS_IDX2_FULL) || (i == INTCS_IDX3_FULL);
    endfunction

    assign idx   = address[10:2];
    assign hit   = is_ctl(idx);
    assign acc   = (read || write) && !ack_r;
    // one wait cycle: the request is acknowledged on the second edge
    assign wr_go = write && ack_r;

    // registered so the bus sees it straight from a flop; always the
    // inverse of ack_r, high while idle and in the first request cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !acc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (acc && read && hit) begin
            readdata <= {24'h00_0000, ctl_r[7:1], pc_flag_r};
        end else if (acc) begin
            readdata <= 32'h0000_0000;
        end
    end

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_d_r  <= 1'b0;
            up_s1_r  <= 4'h0;
            up_s2_r  <= 4'h0;
        end else begin
            pin_s1_r <= external_irq_pin;
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
            up_s1_r  <= upper_port_pins;
            up_s2_r  <= up_s1_r;
        end
    end

    // the pin may idle high; until the pipeline holds real samples a
    // reset value of zero would look like an edge, so detection waits
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_fill_r <= 2'h0;
        end else if (sync_fill_r != SYNC_FILL) begin
            sync_fill_r <= sync_fill_r + 2'h1;
        end
    end

    assign edge_armed = (sync_fill_r == SYNC_FILL);
    assign ext_edge   = edge_armed && (external_edge_select ? (pin_s2_r && !pin_d_r)
                                                            : (!pin_s2_r && pin_d_r));
    assign mismatch = (up_s2_r != up_latch_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            up_latch_r <= PORT_LATCH_RST;
        end else if (port_read) begin
            up_latch_r <= up_s2_r;
        end
    end

    // control and flag bits; a source event wins over a software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_r <= INTCS_RESET;
        end else begin
            if (wr_go && hit) begin
                ctl_r[7:1] <= writedata[7:1];
            end
            if (timer0_overflow) begin
                ctl_r[BIT_T0F_POS] <= 1'b1;
            end
            if (ext_edge) begin
                ctl_r[BIT_EXF_POS] <= 1'b1;
            end
        end
    end

    // bit 0 has no reset value, so it is left out of the reset branch
    // a live mismatch wins over a written 0, so a clear cannot hide a change
    always_ff @(posedge clk) begin
        if (wr_go && hit) begin
            pc_flag_r <= writedata[0] || mismatch;
        end else if (mismatch) begin
            pc_flag_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            core_irq_r <= 1'b0;
        end else begin
            core_irq_r <= ctl_r[BIT_GLOBAL_POS] && (
                (ctl_r[BIT_PEN_POS] && periph_request) ||
                (ctl_r[BIT_T0E_POS] && ctl_r[BIT_T0F_POS]) ||
                (ctl_r[BIT_EXE_POS] && ctl_r[BIT_EXF_POS]) ||
                (ctl_r[BIT_PCE_POS] && pc_flag_r));
        end
    end

    // bus handshake and register access
    AST_READ_ONE_WAIT: assert property (@(posedge clk) disable iff (rst)
        (read && !ack_r) |=> !waitrequest)
        else $error("read not acknowledged after one wait cycle");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (rst)
        (read && !ack_r && !hit) |=> (readdata == 32'h0000_0000))
        else $error("unmapped read returned data");

    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (rst)
        (wr_go && hit) |=> (ctl_r[7:3] == $past(writedata[7:3])))
        else $error("enable bits not written");

    AST_RESET_CLEARS: assert property (@(posedge clk)
        rst |=> (ctl_r == 8'h00))
        else $error("control bits not cleared by reset");

    // request gating
    AST_GLOBAL_GATE: assert property (@(posedge clk) disable iff (rst)
        !ctl_r[BIT_GLOBAL_POS] |=> !core_irq_r)
        else $error("request passed with global enable clear");

    AST_PERIPH_PASS: assert property (@(posedge clk) disable iff (rst)
        (ctl_r[BIT_GLOBAL_POS] && ctl_r[BIT_PEN_POS] && periph_request) |=> core_irq_r)
        else $error("peripheral request not passed");

    AST_PERIPH_GATE: assert property (@(posedge clk) disable iff (rst)
        (!ctl_r[BIT_PEN_POS] && !ctl_r[BIT_T0E_POS] && !ctl_r[BIT_EXE_POS]
         && !ctl_r[BIT_PCE_POS]) |=> !core_irq_r)
        else $error("request passed with all enables clear");

    AST_TIMER_REQ: assert property (@(posedge clk) disable iff (rst)
        (ctl_r[BIT_GLOBAL_POS] && ctl_r[BIT_T0E_POS] && ctl_r[BIT_T0F_POS]) |=> core_irq_r)
        else $error("timer request not raised");

    AST_EXT_REQ: assert property (@(posedge clk) disable iff (rst)
        (ctl_r[BIT_GLOBAL_POS] && ctl_r[BIT_EXE_POS] && ctl_r[BIT_EXF_POS]) |=> core_irq_r)
        else $error("external request not raised");

    AST_ENABLES_SUPPRESS: assert property (@(posedge clk) disable iff (rst)
        (!ctl_r[BIT_T0E_POS] && !ctl_r[BIT_EXE_POS] && !ctl_r[BIT_PCE_POS]
         && !(ctl_r[BIT_PEN_POS] && periph_request)) |=> !core_irq_r)
        else $error("masked flag raised a request");

    // flag setting and port relatch
    AST_TIMER_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
        timer0_overflow |=> ctl_r[BIT_T0F_POS])
        else $error("timer flag not set");

    AST_EDGE_FLAG: assert property (@(posedge clk) disable iff (rst)
        (edge_armed && external_edge_select && pin_s2_r && !pin_d_r) |=> ctl_r[BIT_EXF_POS])
        else $error("rising edge not flagged");

    AST_FALL_FLAG: assert property (@(posedge clk) disable iff (rst)
        (edge_armed && !external_edge_select && !pin_s2_r && pin_d_r) |=> ctl_r[BIT_EXF_POS])
        else $error("falling edge not flagged");

    AST_PORT_CHANGE: assert property (@(posedge clk) disable iff (rst)
        (up_s2_r != up_latch_r) |=> pc_flag_r)
        else $error("port change not flagged");

    AST_RELATCH: assert property (@(posedge clk) disable iff (rst)
        port_read |=> (up_latch_r == $past(up_s2_r)))
        else $error("port read did not relatch the pins");
endmodule
`default_nettype wire

// ===== irq_ctl_pkg.sv
`default_nettype none
package irq_ctl_pkg;
    // register index; the byte address on the bus is four times the index
    localparam logic [8:0] INTCS_IDX2_FULL = 9'h10B;
    localparam logic [8:0] INTCS_IDX3_FULL = 9'h18B;
    localparam logic [8:0] INTCS_IDX0_FULL = 9'h00B;
    localparam logic [8:0] INTCS_IDX1_FULL = 9'h08B;
    localparam int         BIT_GLOBAL_POS  = 7;
    localparam int         BIT_PEN_POS     = 6;
    localparam int         BIT_T0E_POS     = 5;
    localparam int         BIT_EXE_POS     = 4;
    localparam int         BIT_PCE_POS     = 3;
    localparam int         BIT_T0F_POS     = 2;
    localparam int         BIT_EXF_POS     = 1;
    localparam int         BIT_PCF_POS     = 0;
    localparam logic [7:0] INTCS_RESET     = 8'h00;
    localparam logic [3:0] PORT_LATCH_RST  = 4'h0;
    // edges after reset before the pin pipeline holds real samples
    localparam logic [1:0] SYNC_FILL       = 2'h3;
endpackage
`default_nettype wire

// ===== irq_entry_model.sv
`timescale 1ns/1ns
`default_nettype none
module irq_entry_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic core_irq_r,
    output var  logic irq_seen
);
    // the core only samples the request on its own clock edge
    always_ff @(posedge clk) irq_seen <= rst ? 1'b0 : core_irq_r;
endmodule
`default_nettype wire

// ===== core_interrupt_control_register_tb.sv
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_register_tb;
    import irq_ctl_pkg::*;
    logic        clk = 0, rst = 1, read = 0, write = 0, tov = 0, preq = 0;
    logic        esel = 0, epin = 0, prd = 0, waitrequest, core_irq_r, irq_seen;
    logic [10:0] address = 0;
    logic [31:0] writedata = 0, readdata;
    logic [3:0]  pins = 0;
    logic [7:0]  q, d;
    int          fails = 0, n_tests = 0, seed = 53141;
    always #20 clk = ~clk;
    core_interrupt_control_register dut_u (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .timer0_overflow(tov), .periph_request(preq),
        .external_edge_select(esel), .external_irq_pin(epin), .upper_port_pins(pins),
        .port_read(prd), .core_irq_r(core_irq_r));
    irq_entry_model core_u (.clk(clk), .rst(rst), .core_irq_r(core_irq_r), .irq_seen(irq_seen));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ends with an idle edge so the strobe is never reassigned in one step
    task automatic bus(input logic wr, input logic [10:0] a, input logic [7:0] v);
        address <= a;
        writedata <= {24'h00_0000, v};
        write <= wr;
        read <= ~wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] irq_exp(input logic [7:0] r, input logic p);
        return {7'h00, r[7] & ((r[6] & p) | (r[5] & r[2]) | (r[4] & r[1]) | (r[3] & r[0]))};
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, 11'h02c, 0);
        chk(q & 8'hfe, 8'h00);
        bus(0, 11'h030, 0);
        chk(q, 8'h00);
        prd <= 1'b1;
        @(posedge clk);
        prd <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            d = 8'($random(seed));
            if (i == 0) d = 8'hff;
            preq <= d[3] ^ d[6];
            bus(1, {i[1:0], 9'h02c}, d);
            bus(0, {~i[1:0], 9'h02c}, 0);
            chk(q, d);
            chk({7'h00, irq_seen}, irq_exp(d, preq));
        end
        bus(1, 11'h02c, 8'h00);
        epin <= 1'b1;
        repeat (6) @(posedge clk);
        bus(0, 11'h22c, 0);
        chk(q, 8'h00);
        epin <= 1'b0;
        tov <= 1'b1;
        @(posedge clk);
        tov <= 1'b0;
        repeat (6) @(posedge clk);
        bus(0, 11'h42c, 0);
        chk(q, 8'h06);
        bus(1, 11'h02c, 8'h00);
        esel <= 1'b1;
        epin <= 1'b1;
        pins <= 4'h5;
        repeat (6) @(posedge clk);
        bus(0, 11'h62c, 0);
        chk(q, 8'h03);
        prd <= 1'b1;
        @(posedge clk);
        prd <= 1'b0;
        bus(1, 11'h02c, 8'h00);
        bus(0, 11'h02c, 0);
        chk(q, 8'h00);
        bus(1, 11'h42c, 8'hfe);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({6'h00, waitrequest, core_irq_r}, 8'h02);
        bus(1, 11'h030, 8'hff);
        bus(0, 11'h62c, 0);
        chk(q & 8'hfe, 8'h00);
        finish_test;
    end
    initial begin
        #100000;
        fails++;
        finish_test;
    end
endmodule
`default_nettype wire
